// ===== bench/carm_tb.sv
// Self-checking bench for the current converter result monitor.
// Assumes carm_pkg and carm_top are compiled first; APB master and converter pulses are driven here.
`timescale 1ns/1ps
module tb;
   import carm_pkg::*;
   logic pclk;
   logic presetn;
   logic [31:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   carm_res_s cur_res;
   carm_cal_s cal_in;
   carm_ctl_s ctl;
   logic conv_irq;
   int err_count;
   int total_checks;
   int cyc;
   logic [31:0] rdat;
   logic rerr;
   localparam int LIMIT = 12000;

   carm_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cur_res(cur_res), .cal_in(cal_in), .ctl(ctl), .conv_irq(conv_irq));

   // Clock source
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_count++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer: setup, access until pready, release after the sampling edge
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0000_0000);
      check(rdat, exp);
   endtask

   // One-cycle current result pulse
   task automatic res(input logic [15:0] d);
      @(posedge pclk);
      cur_res <= {1'b1, d};
      @(posedge pclk);
      cur_res <= {1'b0, d};
   endtask

   // One-cycle calibration answer pulse
   task automatic cal(input logic [15:0] v);
      @(posedge pclk);
      cal_in <= {1'b1, v};
      @(posedge pclk);
      cal_in <= {1'b0, v};
   endtask

   task automatic ctl_gain(input logic [9:0] g, input logic lp);
      repeat (2) @(posedge pclk);
      check({22'h0, ctl.pga_gain}, {22'h0, g});
      check({31'h0, ctl.lp_clk_sel}, {31'h0, lp});
      check({31'h0, ctl.vt_run}, {31'h0, ~lp});
      check({31'h0, ctl.keep_pll}, {31'h0, ~lp});
   endtask

   initial begin
      cyc = 0;
      err_count = 0;
      total_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      cur_res = '0;
      cal_in = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values
      rd_chk(A_RCL, 32'h0000_0001);
      rd_chk(A_TCL, 32'h0000_0001);
      rd_chk(A_RCV, 32'h0000_0000);
      rd_chk(A_THV, 32'h0000_0000);
      rd_chk(A_ACC, 32'h0000_0000);
      rd_chk(A_TH, 32'h0000_0000);
      rd_chk(A_REF, {16'h0, REF_DEF});
      rd_chk(32'hFFFF_0560, 32'h0000_0000);
      check({31'h0, rerr}, 32'h0000_0001);
      // Start-up order; settling waits only matter to the analog side, so they are short
      wr(A_CTRL, 32'h0000_8007);
      wr(A_MODE, 32'h0000_0009);
      repeat (20) @(posedge pclk);
      wr(A_MODE, 32'h0000_0003);
      repeat (20) @(posedge pclk);
      // Result counter with limit three, wrap and event
      wr(A_CTRL, 32'h0000_8003);
      wr(A_MODE, 32'h0000_0001);
      wr(A_CFG, 32'h0000_0001);
      wr(A_RCL, 32'h0000_0003);
      res(16'h0010);
      res(16'h0010);
      rd_chk(A_RCV, 32'h0000_0002);
      check({31'h0, conv_irq}, 32'h0000_0000);
      res(16'h0010);
      rd_chk(A_RCV, 32'h0000_0000);
      rd_chk(A_STAT, 32'h0000_0003);
      check({31'h0, conv_irq}, 32'h0000_0001);
      wr(A_STAT, 32'h0000_0003);
      @(posedge pclk);
      check({31'h0, conv_irq}, 32'h0000_0000);
      res(16'h0010);
      wr(A_CTRL, 32'h0000_8003);
      rd_chk(A_RCV, 32'h0000_0000);
      res(16'h0010);
      wr(A_MODE, 32'h0000_0001);
      rd_chk(A_RCV, 32'h0000_0000);
      // Accumulator add, subtract, clear
      wr(A_CFG, 32'h0000_0020);
      res(16'h0100);
      res(16'hFFFF);
      rd_chk(A_STAT, 32'h0000_0001);
      rd_chk(A_ACC, 32'h0000_00FF);
      wr(A_CFG, 32'h0000_0040);
      res(16'h0010);
      rd_chk(A_ACC, 32'h0000_00EF);
      wr(A_CFG, 32'h0000_0000);
      rd_chk(A_ACC, 32'h0000_0000);
      wr(A_CFG, 32'h0000_0020);
      res(16'h0005);
      wr(A_MODE, 32'h0000_0001);
      rd_chk(A_ACC, 32'h0000_0000);
      // Persistence comparator, decrement flavour, two's complement
      wr(A_STAT, 32'h0000_001F);
      wr(A_TH, 32'h0000_0100);
      wr(A_TCL, 32'h0000_0002);
      wr(A_CFG, 32'h0000_0010);
      res(16'hFF00);
      rd_chk(A_THV, 32'h0000_0001);
      res(16'h0010);
      res(16'h0010);
      rd_chk(A_THV, 32'h0000_0000);
      res(16'h0100);
      rd_chk(A_STAT, 32'h0000_0001);
      res(16'h7FFF);
      rd_chk(A_THV, 32'h0000_0002);
      rd_chk(A_STAT, 32'h0000_0005);
      check({31'h0, conv_irq}, 32'h0000_0001);
      // Clear flavour and threshold bit width per coding
      wr(A_STAT, 32'h0000_001F);
      wr(A_CFG, 32'h0000_0018);
      res(16'h0010);
      rd_chk(A_THV, 32'h0000_0000);
      wr(A_TH, 32'h0000_8100);
      res(16'h0100);
      rd_chk(A_THV, 32'h0000_0001);
      wr(A_CTRL, 32'h0000_9003);
      res(16'h8000);
      rd_chk(A_THV, 32'h0000_0000);
      res(16'h8100);
      rd_chk(A_THV, 32'h0000_0001);
      // Immediate comparator
      wr(A_STAT, 32'h0000_001F);
      wr(A_CFG, 32'h0000_0008);
      res(16'h0010);
      rd_chk(A_STAT, 32'h0000_0001);
      res(16'h8100);
      rd_chk(A_STAT, 32'h0000_0001);
      res(16'h9000);
      rd_chk(A_STAT, 32'h0000_0009);
      check({31'h0, conv_irq}, 32'h0000_0001);
      wr(A_STAT, 32'h0000_001F);
      wr(A_CFG, 32'h0000_0000);
      // Power modes drive gain and clock select
      wr(A_MODE, 32'h0000_0009);
      ctl_gain(GAIN_LP, 1'b1);
      wr(A_MODE, 32'h0000_0029);
      repeat (2) @(posedge pclk);
      check({31'h0, ctl.ref_precise}, 32'h0000_0001);
      wr(A_MODE, 32'h0000_0011);
      ctl_gain(GAIN_LPP, 1'b1);
      wr(A_MODE, 32'h0000_0001);
      ctl_gain(10'h008, 1'b0);
      // Single conversion falls back to power-down
      wr(A_MODE, 32'h0000_0002);
      res(16'h0001);
      xfer(A_MODE, 1'b0, 32'h0000_0000);
      check({29'h0, rdat[2:0]}, 32'h0000_0000);
      // Coefficient writes gated by idle time
      wr(A_MODE, 32'h0000_0003);
      wr(A_VGAIN, 32'h0000_1234);
      rd_chk(A_VGAIN, {16'h0, GAIN_V_DEF});
      wr(A_TGAIN, 32'h0000_5678);
      rd_chk(A_TGAIN, {16'h0, GAIN_T_DEF});
      repeat (IDLE_CYC + 10) @(posedge pclk);
      wr(A_VGAIN, 32'h0000_1234);
      rd_chk(A_VGAIN, 32'h0000_1234);
      // Gain calibration replaces the coefficient
      wr(A_MODE, 32'h0000_0005);
      cal(16'hABCD);
      rd_chk(A_TGAIN, 32'h0000_ABCD);
      xfer(A_MODE, 1'b0, 32'h0000_0000);
      check({29'h0, rdat[2:0]}, 32'h0000_0003);
      wr(A_MODE, 32'h0000_0004);
      cal(16'h4321);
      rd_chk(A_VGAIN, 32'h0000_4321);
      results();
   end
endmodule

// ===== design/carm_pkg.sv
// Constants, register map and carriers for the current converter result monitor.
// Assumes a 100 MHz APB clock and a converter core that delivers results and calibration values.
package carm_pkg;
   // Register byte addresses
   localparam logic [31:0] A_VGAIN = 32'hFFFF_0540;
   localparam logic [31:0] A_TGAIN = 32'hFFFF_0544;
   localparam logic [31:0] A_RCL = 32'hFFFF_0548;
   localparam logic [31:0] A_RCV = 32'hFFFF_054C;
   localparam logic [31:0] A_TH = 32'hFFFF_0550;
   localparam logic [31:0] A_TCL = 32'hFFFF_0554;
   localparam logic [31:0] A_THV = 32'hFFFF_0558;
   localparam logic [31:0] A_ACC = 32'hFFFF_055C;
   localparam logic [31:0] A_REF = 32'hFFFF_057C;
   localparam logic [31:0] A_MODE = 32'hFFFF_0500;
   localparam logic [31:0] A_CFG = 32'hFFFF_0504;
   localparam logic [31:0] A_CTRL = 32'hFFFF_0508;
   localparam logic [31:0] A_STAT = 32'hFFFF_050C;
   // Reset values
   localparam logic [15:0] RCL_RST = 16'h0001;
   localparam logic [7:0] TCL_RST = 8'h01;
   localparam logic [15:0] GAIN_V_DEF = 16'h8000;
   localparam logic [15:0] GAIN_T_DEF = 16'h8000;
   localparam logic [15:0] REF_DEF = 16'h8000;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   // Conversion mode codes, mode register bits 2:0
   localparam logic [2:0] MD_PDN = 3'h0;
   localparam logic [2:0] MD_CONT = 3'h1;
   localparam logic [2:0] MD_SINGLE = 3'h2;
   localparam logic [2:0] MD_IDLE = 3'h3;
   localparam logic [2:0] MD_GCV = 3'h4;
   localparam logic [2:0] MD_GCT = 3'h5;
   // Power mode codes, mode register bits 4:3
   localparam logic [1:0] PM_NORM = 2'h0;
   localparam logic [1:0] PM_LP = 2'h1;
   localparam logic [1:0] PM_LPP = 2'h2;
   // Field positions
   localparam int MODE_PM_LO = 3;
   localparam int MODE_REF_BIT = 5;
   localparam int CFG_RCE_BIT = 0;
   localparam int CFG_CMP_LO = 3;
   localparam int CFG_ACC_LO = 5;
   localparam int CTRL_EN_BIT = 15;
   localparam int CTRL_UNI_BIT = 12;
   // Comparator and accumulator field codes
   localparam logic [1:0] CMP_OFF = 2'h0;
   localparam logic [1:0] CMP_IMM = 2'h1;
   localparam logic [1:0] CMP_DEC = 2'h2;
   localparam logic [1:0] ACC_OFF = 2'h0;
   localparam logic [1:0] ACC_SUB = 2'h2;
   // Status bits
   localparam int ST_RDY = 0;
   localparam int ST_CNT = 1;
   localparam int ST_THR = 2;
   localparam int ST_CMP = 3;
   localparam int ST_CAL = 4;
   localparam int ST_W = 5;
   // Gains
   localparam logic [9:0] GAIN_LP = 10'h080;
   localparam logic [9:0] GAIN_LPP = 10'h200;
   localparam logic [3:0] GAIN_CODE_MAX = 4'h9;
   // Idle time before coefficient writes are accepted
   localparam int CLK_PERIOD_NS = 10;
   localparam int IDLE_MIN_NS = 23000;
   localparam int IDLE_CYC = (IDLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] IDLE_CYC_W = 12'(IDLE_CYC);
   // Converter result
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } carm_res_s;
   // Gain calibration answer
   typedef struct packed {
      logic done;
      logic [15:0] value;
   } carm_cal_s;
   // Converter control outputs
   typedef struct packed {
      logic conv_run;
      logic vt_run;
      logic lp_clk_sel;
      logic ref_precise;
      logic keep_pll;
      logic cal_req_v;
      logic cal_req_t;
      logic [9:0] pga_gain;
   } carm_ctl_s;
endpackage

// ===== design/carm_top.sv
// Current converter result monitor: APB registers, result counter, comparator,
// accumulator, gain calibration holding and power mode control.
// Assumes results and calibration answers arrive as one-cycle pulses on pclk.
//
// What this block does
// R01: Gain calibration of voltage or temperature replaces that 16-bit coefficient.
// R02: Coefficient writes only land in idle after 23 us enabled.
// R03: Result count limit sets conversions per event; resets to one.
// R04: Result count rises per result; at limit raises event, wraps to zero.
// R05: Writing control or mode register clears the result count.
// R06: Magnitude compared to threshold, bits 15:0 unipolar, 14:0 twos complement.
// R07: Threshold count increments at or above threshold, else decrements or clears.
// R08: Threshold flag sets when threshold count equals its limit, reset one.
// R09: Two-bit field picks comparator operation; immediate or persistence event.
// R10: 32-bit accumulator adds or subtracts each current result.
// R11: Accumulator clears when disabled or channel reconfigured.
// R12: Software waits for ready before reading the accumulator.
// R13: Software scales low-power results by reference scale over 0x8000.
// R14: Software skips scaling when precision reference is selected.
// R15: Mode register field selects normal, low power or low power-plus.
// R16: Software starts in low power with 0x8007 and 0x09, waits 200 us.
// R17: Software then selects idle with 0x03, waits 1 ms, then mode.
// R18: Normal mode runs all channels from the fast modulator clock.
// R19: Single conversion returns the converter to power-down afterwards.
// R20: Software keeps the PLL powered in normal mode.
// R21: Low power runs current channel only, slow clock, gain 128.
// R22: Low power-plus as low power with gain 512; functions stay usable.
// R23: Field picks decrement or clear; count floors at zero, stops rising when flagged.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module carm_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [31:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter core
   input carm_pkg::carm_res_s cur_res,
   input carm_pkg::carm_cal_s cal_in,
   output carm_pkg::carm_ctl_s ctl,
   output logic conv_irq
);
   import carm_pkg::*;

   logic [15:0] vgain_r, tgain_r, rcl_r, rcv_r, th_r, ref_r, ctrl_r;
   logic [7:0] tcl_r, thv_r, mode_r, cfg_r;
   logic [31:0] acc_r;
   logic [ST_W-1:0] stat_r;
   logic [11:0] idle_cnt_r;
   logic [31:0] prdata_r;
   logic err_r;
   carm_ctl_s ctl_r;
   logic wr, setup, hit;
   logic wr_mode, wr_ctrl, wr_cfg, wr_stat, reconf;
   logic coef_ok, res, uni, ge;
   logic [2:0] mfn;
   logic [1:0] pm, cmp, accm;
   logic [15:0] mag, thr, rcv_inc;
   logic [31:0] ext;
   logic [7:0] thv_nxt;
   logic thv_upd;
   logic [ST_W-1:0] st_set;
   logic [3:0] gsh;
   logic [31:0] ext_rd;

   // Bus decode
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign wr_mode = wr && paddr == A_MODE;
   assign wr_ctrl = wr && paddr == A_CTRL;
   assign wr_cfg = wr && paddr == A_CFG;
   assign wr_stat = wr && paddr == A_STAT;
   assign reconf = wr_mode || wr_ctrl;
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = psel && penable && err_r;

   // Field views
   assign mfn = mode_r[2:0];
   assign pm = mode_r[MODE_PM_LO +: 2];
   assign cmp = cfg_r[CFG_CMP_LO +: 2];
   assign accm = cfg_r[CFG_ACC_LO +: 2];
   assign uni = ctrl_r[CTRL_UNI_BIT];
   assign res = cur_res.valid;

   // Magnitude and threshold selection
   always_comb begin
      if (uni) begin
         mag = cur_res.data;
         thr = th_r; // R06
      end else begin
         mag = cur_res.data[15] ? 16'(~cur_res.data + 16'h0001) : cur_res.data;
         thr = {1'b0, th_r[14:0]}; // R06
      end
   end
   assign ge = mag >= thr;
   assign ext = uni ? {16'h0000, cur_res.data} : {{16{cur_res.data[15]}}, cur_res.data};
   assign rcv_inc = 16'(rcv_r + 16'h0001);

   // Threshold count next value
   always_comb begin
      thv_nxt = thv_r;
      thv_upd = res && (cmp == CMP_DEC || cmp == 2'h3);
      if (ge) begin
         if (!stat_r[ST_THR] && thv_r != 8'hFF)
            thv_nxt = 8'(thv_r + 8'h01); // R07 R23
      end else if (cmp == CMP_DEC) begin
         if (thv_r != 8'h00)
            thv_nxt = 8'(thv_r - 8'h01); // R23
      end else begin
         thv_nxt = 8'h00; // R07
      end
   end

   // Hardware status events
   always_comb begin
      st_set = '0;
      st_set[ST_RDY] = res;
      st_set[ST_CNT] = res && cfg_r[CFG_RCE_BIT] && !reconf && rcv_inc == rcl_r; // R04
      st_set[ST_THR] = thv_upd && thv_nxt == tcl_r; // R08
      // Immediate event needs a strict overshoot, unlike the persistence count
      st_set[ST_CMP] = res && cmp == CMP_IMM && mag > thr; // R09
      st_set[ST_CAL] = cal_in.done && (mfn == MD_GCV || mfn == MD_GCT);
   end

   // Idle timer gating coefficient writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         idle_cnt_r <= 12'h000;
      else if (mfn != MD_IDLE || !ctrl_r[CTRL_EN_BIT] || reconf)
         idle_cnt_r <= 12'h000;
      else if (idle_cnt_r != IDLE_CYC_W)
         idle_cnt_r <= 12'(idle_cnt_r + 12'h001);
   end
   assign coef_ok = mfn == MD_IDLE && ctrl_r[CTRL_EN_BIT] && idle_cnt_r == IDLE_CYC_W; // R02

   // Gain coefficients
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vgain_r <= GAIN_V_DEF;
         tgain_r <= GAIN_T_DEF;
      end else begin
         if (cal_in.done && mfn == MD_GCV)
            vgain_r <= cal_in.value; // R01
         else if (wr && paddr == A_VGAIN && coef_ok)
            vgain_r <= pwdata[15:0]; // R02
         if (cal_in.done && mfn == MD_GCT)
            tgain_r <= cal_in.value; // R01
         else if (wr && paddr == A_TGAIN && coef_ok)
            tgain_r <= pwdata[15:0]; // R02
      end
   end

   // Plain software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rcl_r <= RCL_RST; // R03
         th_r <= 16'h0000;
         tcl_r <= TCL_RST; // R08
         ref_r <= REF_DEF;
         cfg_r <= 8'h00;
         ctrl_r <= CTRL_RST;
      end else if (wr) begin
         if (paddr == A_RCL)
            rcl_r <= pwdata[15:0];
         if (paddr == A_TH)
            th_r <= pwdata[15:0];
         if (paddr == A_TCL)
            tcl_r <= pwdata[7:0];
         if (paddr == A_REF)
            ref_r <= pwdata[15:0];
         if (wr_cfg)
            cfg_r <= pwdata[7:0];
         if (wr_ctrl)
            ctrl_r <= pwdata[15:0];
      end
   end

   // Mode register with hardware returns
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mode_r <= MODE_RST;
      else if (wr_mode)
         mode_r <= pwdata[7:0]; // R15
      else if (mfn == MD_SINGLE && res)
         mode_r[2:0] <= MD_PDN; // R19
      else if (st_set[ST_CAL])
         mode_r[2:0] <= MD_IDLE;
   end

   // Result counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rcv_r <= 16'h0000;
      else if (reconf)
         rcv_r <= 16'h0000; // R05
      else if (res && cfg_r[CFG_RCE_BIT]) begin
         if (rcv_inc == rcl_r)
            rcv_r <= 16'h0000; // R04
         else
            rcv_r <= rcv_inc; // R03 R04
      end
   end

   // Threshold persistence count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         thv_r <= 8'h00;
      else if (thv_upd)
         thv_r <= thv_nxt; // R07
   end

   // Accumulator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         acc_r <= 32'h0000_0000;
      else if (reconf || accm == ACC_OFF)
         acc_r <= 32'h0000_0000; // R11
      else if (res) begin
         if (accm == ACC_SUB)
            acc_r <= 32'(acc_r - ext); // R10
         else
            acc_r <= 32'(acc_r + ext); // R10
      end
   end

   // Status flags: hardware set wins over a write-one clear
   generate
      for (genvar i = 0; i < ST_W; i++) begin : g_stat
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
               stat_r[i] <= 1'b0;
            else if (st_set[i])
               stat_r[i] <= 1'b1;
            else if (wr_stat && pwdata[i])
               stat_r[i] <= 1'b0;
         end
      end
   endgenerate
   assign conv_irq = |stat_r[ST_CMP:ST_CNT];

   // Converter control outputs
   assign gsh = ctrl_r[3:0] > GAIN_CODE_MAX ? GAIN_CODE_MAX : ctrl_r[3:0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctl_r <= '0;
      else begin
         ctl_r.conv_run <= ctrl_r[CTRL_EN_BIT] && (mfn == MD_CONT || mfn == MD_SINGLE);
         ctl_r.vt_run <= pm == PM_NORM && (mfn == MD_CONT || mfn == MD_SINGLE); // R18 R21
         ctl_r.lp_clk_sel <= pm != PM_NORM; // R21 R22
         ctl_r.ref_precise <= mode_r[MODE_REF_BIT];
         ctl_r.keep_pll <= pm == PM_NORM && mfn != MD_PDN; // R18
         ctl_r.cal_req_v <= mfn == MD_GCV;
         ctl_r.cal_req_t <= mfn == MD_GCT;
         if (pm == PM_LP)
            ctl_r.pga_gain <= GAIN_LP; // R21
         else if (pm == PM_LPP)
            ctl_r.pga_gain <= GAIN_LPP; // R22
         else
            ctl_r.pga_gain <= 10'(10'h001 << gsh); // R15
      end
   end
   assign ctl = ctl_r;

   // Read mux, captured in the setup cycle
   always_comb begin
      hit = 1'b1;
      unique case (paddr)
         A_VGAIN: ext_rd = {16'h0000, vgain_r};
         A_TGAIN: ext_rd = {16'h0000, tgain_r};
         A_RCL: ext_rd = {16'h0000, rcl_r};
         A_RCV: ext_rd = {16'h0000, rcv_r};
         A_TH: ext_rd = {16'h0000, th_r};
         A_TCL: ext_rd = {24'h000000, tcl_r};
         A_THV: ext_rd = {24'h000000, thv_r};
         A_ACC: ext_rd = acc_r;
         A_REF: ext_rd = {16'h0000, ref_r};
         A_MODE: ext_rd = {24'h000000, mode_r};
         A_CFG: ext_rd = {24'h000000, cfg_r};
         A_CTRL: ext_rd = {16'h0000, ctrl_r};
         A_STAT: ext_rd = {27'h0000000, stat_r};
         default: begin
            ext_rd = 32'h0000_0000;
            hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
      end else if (setup) begin
         prdata_r <= pwrite ? 32'h0000_0000 : ext_rd;
         err_r <= !hit;
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_gain_cal;
      (cal_in.done && mfn == MD_GCV) |=> vgain_r == $past(cal_in.value);
   endproperty
   a_gain_cal: assert property (p_gain_cal) else $error("voltage gain not replaced"); // R01

   property p_coef_lock;
      (wr && paddr == A_TGAIN && !coef_ok && !cal_in.done) |=> $stable(tgain_r);
   endproperty
   a_coef_lock: assert property (p_coef_lock) else $error("coefficient written outside idle"); // R02

   property p_cnt_wrap;
      st_set[ST_CNT] |=> rcv_r == 16'h0000 && stat_r[ST_CNT];
   endproperty
   a_cnt_wrap: assert property (p_cnt_wrap) else $error("result count did not wrap"); // R04

   property p_cnt_inc;
      (res && cfg_r[CFG_RCE_BIT] && !reconf && rcv_inc != rcl_r) |=> rcv_r == 16'($past(rcv_r) + 16'h0001);
   endproperty
   a_cnt_inc: assert property (p_cnt_inc) else $error("result count did not step"); // R03

   property p_reconf;
      reconf |=> rcv_r == 16'h0000 && acc_r == 32'h0000_0000;
   endproperty
   a_reconf: assert property (p_reconf) else $error("reconfigure did not clear"); // R05

   property p_acc_off;
      accm == ACC_OFF |=> acc_r == 32'h0000_0000;
   endproperty
   a_acc_off: assert property (p_acc_off) else $error("accumulator not cleared"); // R11

   property p_acc_add;
      (res && !reconf && accm == 2'h1 && !wr_cfg) |=> acc_r == 32'($past(acc_r) + $past(ext));
   endproperty
   a_acc_add: assert property (p_acc_add) else $error("accumulator add wrong"); // R10

   property p_thv_inc;
      (thv_upd && ge && !stat_r[ST_THR] && thv_r != 8'hFF && !wr_cfg) |=> thv_r == 8'($past(thv_r) + 8'h01);
   endproperty
   a_thv_inc: assert property (p_thv_inc) else $error("threshold count not incremented"); // R07

   property p_thv_clr;
      (thv_upd && !ge && cmp == 2'h3) |=> thv_r == 8'h00;
   endproperty
   a_thv_clr: assert property (p_thv_clr) else $error("threshold count not cleared"); // R07

   property p_thr_flag;
      (thv_upd && thv_nxt == tcl_r) |=> stat_r[ST_THR] ##1 (stat_r[ST_THR] || $past(wr_stat));
   endproperty
   a_thr_flag: assert property (p_thr_flag) else $error("threshold flag missing"); // R08

   property p_cmp_imm;
      (res && cmp == CMP_IMM && mag > thr) |=> stat_r[ST_CMP] && conv_irq;
   endproperty
   a_cmp_imm: assert property (p_cmp_imm) else $error("comparator event missing"); // R09

   property p_single;
      (mfn == MD_SINGLE && res && !wr_mode) |=> mode_r[2:0] == MD_PDN;
   endproperty
   a_single: assert property (p_single) else $error("single conversion did not stop"); // R19

   property p_lp_gain;
      (pm == PM_LP && !wr_mode) ##1 pm == PM_LP |-> ctl.pga_gain == GAIN_LP && ctl.lp_clk_sel && !ctl.vt_run;
   endproperty
   a_lp_gain: assert property (p_lp_gain) else $error("low power gain wrong"); // R21

   property p_lpp_gain;
      pm == PM_LPP ##1 pm == PM_LPP |-> ctl.pga_gain == GAIN_LPP;
   endproperty
   a_lpp_gain: assert property (p_lpp_gain) else $error("low power-plus gain wrong"); // R22
endmodule
